// ===== core/ccd_pkg.sv
// Package for the clear, complement, decrement and call instruction group.
package ccd_pkg;

    // ------------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------------
    localparam int DATA_W = 8;
    localparam int FADDR_W = 7;
    localparam int PC_W = 15;
    localparam int LATCH_W = 7;
    localparam int SP_W = 4;
    localparam int FILE_DEPTH = 128;
    localparam int STACK_DEPTH = 16;
    localparam int PADDR_W = 8;

    // ------------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_INSTR = 8'h00;
    localparam logic [7:0] OFS_ACCUM = 8'h04;
    localparam logic [7:0] OFS_LATCH = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0c;
    localparam logic [7:0] OFS_PC = 8'h10;
    localparam logic [7:0] OFS_FADDR = 8'h14;
    localparam logic [7:0] OFS_FDATA = 8'h18;
    localparam logic [7:0] OFS_STACK = 8'h1c;
    localparam logic [7:0] OFS_WATCHDOG = 8'h20;
    localparam logic [7:0] OFS_CTRL = 8'h24;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int INSTR_OP_LSB = 0;
    localparam int INSTR_DEST_BIT = 4;
    localparam int INSTR_FADDR_LSB = 8;
    localparam int STATUS_Z_BIT = 2;
    localparam int STATUS_PD_BIT = 3;
    localparam int STATUS_TO_BIT = 4;
    localparam int STACK_SP_LSB = 16;
    localparam int WATCHDOG_PRESC_LSB = 8;
    localparam int CTRL_BUSY_BIT = 0;
    localparam int CTRL_SKIP_BIT = 1;

    // ------------------------------------------------------------------
    // Reset values and constants
    // ------------------------------------------------------------------
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [14:0] RST_PC = 15'h0000;
    localparam logic [3:0] RST_SP = 4'h0;
    localparam logic RST_FLAG_N = 1'b1;
    localparam logic RST_Z = 1'b0;
    localparam logic [7:0] ONE_BYTE = 8'h01;
    localparam logic [14:0] ONE_PC = 15'h0001;
    localparam logic [3:0] ONE_SP = 4'h1;
    localparam logic [7:0] FULL_BYTE = 8'hff;

    typedef enum logic [3:0] {
        OP_NOP = 4'h0,
        OP_WATCHDOG_CLEAR = 4'h1,
        OP_CALL_VIA_ACCUM = 4'h2,
        OP_COMPLEMENT_FILE = 4'h3,
        OP_CLEAR_FILE = 4'h4,
        OP_CLEAR_ACCUM = 4'h5,
        OP_DECREMENT_FILE = 4'h6,
        OP_DECREMENT_SKIP = 4'h7
    } ccd_opcode_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_EXEC = 3'b010,
        ST_CALL2 = 3'b100
    } ccd_state_t;

    typedef struct packed {
        logic [6:0] faddr;
        logic dest;
        ccd_opcode_t opcode;
    } ccd_instr_t;

    typedef struct packed {
        logic [7:0] result;
        logic wr_accum;
        logic wr_file;
        logic z_upd;
        logic zero;
        logic skip;
    } ccd_exec_res_t;

endpackage

// ===== core/ccd_exec_unit.sv
// Result datapath for the clear, complement and decrement instructions.
`timescale 1ns/1ps
module ccd_exec_unit (
    input wire ccd_pkg::ccd_instr_t instr,
    input wire logic [7:0] file_val,
    output ccd_pkg::ccd_exec_res_t res
);
    import ccd_pkg::*;

    always_comb begin
        res = '0;
        case (instr.opcode)
            OP_COMPLEMENT_FILE: begin
                res.result = ~file_val;
                res.wr_file = instr.dest;
                res.wr_accum = ~instr.dest;
                res.z_upd = 1'b1;
            end
            OP_CLEAR_FILE: begin
                res.result = RST_BYTE;
                res.wr_file = 1'b1;
                res.z_upd = 1'b1;
            end
            OP_CLEAR_ACCUM: begin
                res.result = RST_BYTE;
                res.wr_accum = 1'b1;
                res.z_upd = 1'b1;
            end
            OP_DECREMENT_FILE: begin
                res.result = file_val - ONE_BYTE;
                res.wr_file = instr.dest;
                res.wr_accum = ~instr.dest;
                res.z_upd = 1'b1;
            end
            OP_DECREMENT_SKIP: begin
                res.result = file_val - ONE_BYTE;
                res.wr_file = instr.dest;
                res.wr_accum = ~instr.dest;
                res.skip = (res.result == RST_BYTE);
            end
            default: begin
                res.result = RST_BYTE;
            end
        endcase
        res.zero = (res.result == RST_BYTE);
    end

endmodule

// ===== core/ccd_core.sv
// Instruction execution core for the clear, complement, decrement and call group.
//
// The APB interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/1ps

// Behaviour
// - The watchdog-clear operation loads zero into the watchdog counter.
// - The watchdog-clear operation also zeroes the watchdog prescaler in the same cycle.
// - The watchdog-clear operation sets both active-low timeout and power-down flags only.
// - The call-via-accumulator operation first pushes the program counter plus one.
// - The call then loads the accumulator into pc 7:0 and the high latch 6:0 into pc 14:8.
// - The call takes two cycles and leaves every status flag alone.
// - Complement inverts the addressed file register (address 0 to 127) and updates zero.
// - Complement with destination 0 writes the accumulator, with 1 the file register.
// - Clear-file writes zero into the addressed register and sets the zero flag.
// - Clear-accumulator writes zero into the accumulator and sets the zero flag.
// - Decrement subtracts one, routes the result by destination bit and updates zero.
// - Decrement-and-skip subtracts one, routes the result by destination and keeps flags.
// - A zero decrement-and-skip result discards the next instruction as a no-operation.
module ccd_core (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ccd_pkg::PADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);
    import ccd_pkg::*;

    ccd_state_t state_r;
    ccd_instr_t instr_r;
    logic [7:0] accum_r;
    logic [6:0] latch_r;
    logic z_r;
    logic pd_n_r;
    logic to_n_r;
    logic [14:0] pc_r;
    logic [6:0] faddr_r;
    logic [7:0] file_mem [0:FILE_DEPTH-1];
    logic [14:0] stack_mem [0:STACK_DEPTH-1];
    logic [3:0] sp_r;
    logic [14:0] stack_top;
    logic skip_pend_r;
    logic [7:0] watchdog_counter_r;
    logic [7:0] presc_r;
    logic [31:0] prdata_r;
    logic cap_ok_r;
    logic idle;
    logic hit;
    logic apb_wr;
    logic [31:0] rd_nxt;
    logic [7:0] file_val;
    logic ex_act;
    logic is_wdclr;
    logic is_call;
    logic wd_ovf;
    ccd_exec_res_t ex_res;

    // ------------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------------
    // Read data is captured while the core is idle, so an access waits out
    // any instruction that is still executing.
    assign idle = (state_r == ST_IDLE);
    assign pready = ce & psel & penable & idle & cap_ok_r;
    assign apb_wr = pready & pwrite & hit;
    assign pslverr = pready & ~hit;
    assign prdata = prdata_r;
    assign stack_top = stack_mem[sp_r - ONE_SP];
    assign file_val = file_mem[instr_r.faddr];

    always_comb begin
        hit = 1'b1;
        rd_nxt = 32'h0000_0000;
        case (paddr)
            OFS_INSTR: rd_nxt[14:0] = {instr_r.faddr, 3'b000, instr_r.dest, instr_r.opcode};
            OFS_ACCUM: rd_nxt[7:0] = accum_r;
            OFS_LATCH: rd_nxt[6:0] = latch_r;
            OFS_STATUS: begin
                rd_nxt[STATUS_Z_BIT] = z_r;
                rd_nxt[STATUS_PD_BIT] = pd_n_r;
                rd_nxt[STATUS_TO_BIT] = to_n_r;
            end
            OFS_PC: rd_nxt[14:0] = pc_r;
            OFS_FADDR: rd_nxt[6:0] = faddr_r;
            OFS_FDATA: rd_nxt[7:0] = file_mem[faddr_r];
            OFS_STACK: begin
                rd_nxt[14:0] = stack_top;
                rd_nxt[STACK_SP_LSB +: SP_W] = sp_r;
            end
            OFS_WATCHDOG: begin
                rd_nxt[7:0] = watchdog_counter_r;
                rd_nxt[WATCHDOG_PRESC_LSB +: DATA_W] = presc_r;
            end
            OFS_CTRL: begin
                rd_nxt[CTRL_BUSY_BIT] = ~idle;
                rd_nxt[CTRL_SKIP_BIT] = skip_pend_r;
            end
            default: hit = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= 32'h0000_0000;
            cap_ok_r <= 1'b0;
        end else if (ce) begin
            cap_ok_r <= psel & idle & ~pready;
            if (psel & idle & ~pready) begin
                prdata_r <= rd_nxt;
            end
        end
    end

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    // An instruction whose predecessor asked for a skip still takes its cycle
    // but has no effect other than advancing the program counter.
    assign ex_act = (state_r == ST_EXEC) & ~skip_pend_r;
    assign is_wdclr = ex_act & (instr_r.opcode == OP_WATCHDOG_CLEAR);
    assign is_call = ex_act & (instr_r.opcode == OP_CALL_VIA_ACCUM);

    ccd_exec_unit u_exec (
        .instr(instr_r),
        .file_val(file_val),
        .res(ex_res)
    );

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= ST_IDLE;
            instr_r <= '0;
        end else if (ce) begin
            case (state_r)
                ST_IDLE: begin
                    if (apb_wr && paddr == OFS_INSTR) begin
                        instr_r.opcode <= ccd_opcode_t'(pwdata[INSTR_OP_LSB +: 4]);
                        instr_r.dest <= pwdata[INSTR_DEST_BIT];
                        instr_r.faddr <= pwdata[INSTR_FADDR_LSB +: FADDR_W];
                        state_r <= ST_EXEC;
                    end
                end
                ST_EXEC: begin
                    state_r <= is_call ? ST_CALL2 : ST_IDLE;
                end
                ST_CALL2: state_r <= ST_IDLE;
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            skip_pend_r <= 1'b0;
        end else if (ce && state_r == ST_EXEC) begin
            skip_pend_r <= ~skip_pend_r & ex_res.skip;
        end
    end

    // ------------------------------------------------------------------
    // Program counter and return stack
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pc_r <= RST_PC;
        end else if (ce) begin
            if (apb_wr && paddr == OFS_PC) begin
                pc_r <= pwdata[14:0];
            end else if (state_r == ST_CALL2) begin
                pc_r <= {latch_r, accum_r};
            end else if (state_r == ST_EXEC && !is_call) begin
                pc_r <= pc_r + ONE_PC;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sp_r <= RST_SP;
        end else if (ce && is_call) begin
            sp_r <= sp_r + ONE_SP;
        end
    end

    for (genvar gs = 0; gs < STACK_DEPTH; gs++) begin : g_stack
        localparam logic [3:0] SIDX = 4'(gs);
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                stack_mem[gs] <= RST_PC;
            end else if (ce && is_call && sp_r == SIDX) begin
                stack_mem[gs] <= pc_r + ONE_PC;
            end
        end
    end

    // ------------------------------------------------------------------
    // Accumulator, high latch, file registers
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            accum_r <= RST_BYTE;
            latch_r <= 7'h00;
            faddr_r <= 7'h00;
        end else if (ce) begin
            if (apb_wr && paddr == OFS_ACCUM) begin
                accum_r <= pwdata[7:0];
            end else if (ex_act && ex_res.wr_accum) begin
                accum_r <= ex_res.result;
            end
            if (apb_wr && paddr == OFS_LATCH) begin
                latch_r <= pwdata[6:0];
            end
            if (apb_wr && paddr == OFS_FADDR) begin
                faddr_r <= pwdata[6:0];
            end
        end
    end

    for (genvar gf = 0; gf < FILE_DEPTH; gf++) begin : g_file
        localparam logic [6:0] FIDX = 7'(gf);
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                file_mem[gf] <= RST_BYTE;
            end else if (ce) begin
                if (apb_wr && paddr == OFS_FDATA && faddr_r == FIDX) begin
                    file_mem[gf] <= pwdata[7:0];
                end else if (ex_act && ex_res.wr_file && instr_r.faddr == FIDX) begin
                    file_mem[gf] <= ex_res.result;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Status flags and watchdog
    // ------------------------------------------------------------------
    // A clear in the same cycle as a watchdog overflow wins, as the clear
    // also restarts the count. A software write cannot hide an overflow.
    assign wd_ovf = (presc_r == FULL_BYTE) && (watchdog_counter_r == FULL_BYTE);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            z_r <= RST_Z;
            pd_n_r <= RST_FLAG_N;
            to_n_r <= RST_FLAG_N;
        end else if (ce) begin
            if (apb_wr && paddr == OFS_STATUS) begin
                z_r <= pwdata[STATUS_Z_BIT];
                pd_n_r <= pwdata[STATUS_PD_BIT];
                to_n_r <= pwdata[STATUS_TO_BIT] & ~wd_ovf;
            end else begin
                if (ex_act && ex_res.z_upd) begin
                    z_r <= ex_res.zero;
                end
                if (is_wdclr) begin
                    pd_n_r <= 1'b1;
                    to_n_r <= 1'b1;
                end else if (wd_ovf) begin
                    to_n_r <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            watchdog_counter_r <= RST_BYTE;
            presc_r <= RST_BYTE;
        end else if (ce) begin
            if (is_wdclr) begin
                watchdog_counter_r <= RST_BYTE;
                presc_r <= RST_BYTE;
            end else begin
                presc_r <= presc_r + ONE_BYTE;
                if (presc_r == FULL_BYTE) begin
                    watchdog_counter_r <= watchdog_counter_r + ONE_BYTE;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    watchdog_zero_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (ce && is_wdclr) |=> watchdog_counter_r == RST_BYTE)
        else $error("watchdog counter not cleared");

    prescaler_zero_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (ce && is_wdclr) |=> presc_r == RST_BYTE && watchdog_counter_r == RST_BYTE)
        else $error("prescaler not cleared with counter");

    flags_set_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (ce && is_wdclr) |=> pd_n_r && to_n_r && z_r == $past(z_r))
        else $error("watchdog clear flag update wrong");

    call_push_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (ce && is_call) |=> stack_top == $past(pc_r) + ONE_PC && sp_r == $past(sp_r) + ONE_SP)
        else $error("return address not pushed");

    call_target_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (ce && is_call) ##1 ce |=> pc_r == {$past(latch_r), $past(accum_r)})
        else $error("call target wrong");

    call_two_cycles_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (ce && is_call) ##1 ce |=> state_r == ST_IDLE && z_r == $past(z_r, 2)
            && to_n_r == $past(to_n_r, 2))
        else $error("call length or flags wrong");

    zero_flag_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (ce && ex_act && ex_res.z_upd) |=> z_r == ($past(ex_res.result) == RST_BYTE))
        else $error("zero flag does not follow result");

    comp_dest_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (ce && ex_act && instr_r.opcode == OP_COMPLEMENT_FILE && !instr_r.dest)
        |=> accum_r == ~$past(file_val))
        else $error("complement result not in accumulator");

    clear_zero_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (ce && ex_act && instr_r.opcode inside {OP_CLEAR_FILE, OP_CLEAR_ACCUM})
        |=> z_r && (accum_r == RST_BYTE || $past(instr_r.opcode) == OP_CLEAR_FILE))
        else $error("clear did not set zero");

    skip_flags_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (ce && ex_act && instr_r.opcode == OP_DECREMENT_SKIP)
        |=> z_r == $past(z_r) && skip_pend_r == ($past(file_val) == ONE_BYTE))
        else $error("decrement-skip flags or skip wrong");

    single_cycle_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (ce && state_r == ST_EXEC && !is_call) |=> state_r == ST_IDLE
            && pc_r == $past(pc_r) + ONE_PC)
        else $error("single-cycle op took longer");

endmodule

// ===== verification/ccd_host_model.sv
// APB host model that issues register accesses to the instruction core.
`timescale 1ns/1ps
module ccd_host_model (
    input wire logic pclk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
    end

    // One transfer: setup cycle, then access phase held until pready is seen high.
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // A released data bus must not keep showing the last value.
        pwdata <= ~d;
    endtask
endmodule

// ===== verification/clear_complement_decrement_call_ops_tb.sv
// Self-checking testbench for the instruction execution core.
`timescale 1ns/1ps
`define CHK(g, e) begin \
    checks++; \
    if ((g) !== (e)) begin \
        num_errors++; \
        $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); \
    end \
end
module clear_complement_decrement_call_ops_tb;
    import ccd_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic ce = 1'b1;
    logic psel, penable, pwrite, pready, pslverr, err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [3:0] sp0;
    int num_errors = 0;
    int checks = 0;

    always #12.5 pclk = ~pclk;

    ccd_core i_dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr));

    ccd_host_model i_host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

    // ------------------------------------------------------------------
    // Access tasks
    // ------------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        i_host.xfer(1'b1, a, d, q, err);
    endtask

    task automatic rd(input logic [7:0] a);
        i_host.xfer(1'b0, a, 32'h0, q, err);
    endtask

    task automatic chk_rd(input logic [7:0] a, input logic [31:0] e);
        rd(a);
        `CHK(q, e)
    endtask

    task automatic op(input ccd_opcode_t o, input logic d, input logic [6:0] f);
        wr(OFS_INSTR, {17'h0, f, 3'h0, d, o});
    endtask

    task automatic setf(input logic [6:0] f, input logic [7:0] v);
        wr(OFS_FADDR, {25'h0, f});
        wr(OFS_FDATA, {24'h0, v});
    endtask

    task automatic wrap_up();
        $display("checks=%0d num_errors=%0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        setf(7'h7f, 8'h5a);
        op(OP_COMPLEMENT_FILE, 1'b1, 7'h7f);
        chk_rd(OFS_FDATA, 32'ha5);
        chk_rd(OFS_STATUS, 32'h18);
        chk_rd(OFS_PC, 32'h1);
        chk_rd(OFS_INSTR, 32'h7f13);
        setf(7'h00, 8'hff);
        op(OP_COMPLEMENT_FILE, 1'b0, 7'h00);
        chk_rd(OFS_ACCUM, 32'h0);
        chk_rd(OFS_FDATA, 32'hff);
        chk_rd(OFS_STATUS, 32'h1c);
        wr(OFS_FADDR, 32'h7f);
        wr(OFS_STATUS, 32'h18);
        op(OP_CLEAR_FILE, 1'b1, 7'h7f);
        chk_rd(OFS_FDATA, 32'h0);
        chk_rd(OFS_STATUS, 32'h1c);
        wr(OFS_ACCUM, 32'h33);
        wr(OFS_STATUS, 32'h18);
        op(OP_CLEAR_ACCUM, 1'b0, 7'h00);
        chk_rd(OFS_ACCUM, 32'h0);
        chk_rd(OFS_STATUS, 32'h1c);
        setf(7'h10, 8'h01);
        wr(OFS_STATUS, 32'h18);
        op(OP_DECREMENT_FILE, 1'b1, 7'h10);
        chk_rd(OFS_FDATA, 32'h0);
        chk_rd(OFS_STATUS, 32'h1c);
        op(OP_DECREMENT_FILE, 1'b0, 7'h10);
        chk_rd(OFS_ACCUM, 32'hff);
        chk_rd(OFS_FDATA, 32'h0);
        chk_rd(OFS_STATUS, 32'h18);
        setf(7'h20, 8'h02);
        wr(OFS_STATUS, 32'h1c);
        op(OP_DECREMENT_SKIP, 1'b1, 7'h20);
        chk_rd(OFS_FDATA, 32'h1);
        chk_rd(OFS_STATUS, 32'h1c);
        chk_rd(OFS_CTRL, 32'h0);
        wr(OFS_STATUS, 32'h18);
        op(OP_DECREMENT_SKIP, 1'b0, 7'h20);
        chk_rd(OFS_ACCUM, 32'h0);
        chk_rd(OFS_FDATA, 32'h1);
        chk_rd(OFS_STATUS, 32'h18);
        chk_rd(OFS_CTRL, 32'h2);
        wr(OFS_ACCUM, 32'h44);
        wr(OFS_PC, 32'h0100);
        op(OP_CLEAR_ACCUM, 1'b0, 7'h00);
        chk_rd(OFS_ACCUM, 32'h44);
        chk_rd(OFS_STATUS, 32'h18);
        chk_rd(OFS_PC, 32'h0101);
        chk_rd(OFS_CTRL, 32'h0);
        op(OP_CLEAR_ACCUM, 1'b0, 7'h00);
        chk_rd(OFS_ACCUM, 32'h0);
        // A call from the top of the latch range checks every high pc bit.
        wr(OFS_PC, 32'h1234);
        wr(OFS_LATCH, 32'hff);
        wr(OFS_ACCUM, 32'ha7);
        wr(OFS_STATUS, 32'h1c);
        rd(OFS_STACK);
        sp0 = q[19:16];
        op(OP_CALL_VIA_ACCUM, 1'b0, 7'h00);
        chk_rd(OFS_PC, 32'h7fa7);
        chk_rd(OFS_STACK, {12'h0, sp0 + 4'h1, 1'b0, 15'h1235});
        chk_rd(OFS_STATUS, 32'h1c);
        wr(OFS_STATUS, 32'h04);
        repeat (300) @(posedge pclk);
        rd(OFS_WATCHDOG);
        `CHK(q[7:0] != 8'h00, 1'b1)
        op(OP_WATCHDOG_CLEAR, 1'b0, 7'h00);
        // A frozen core executes the clear only once the enable returns.
        ce <= 1'b0;
        repeat (20) @(posedge pclk);
        ce <= 1'b1;
        rd(OFS_WATCHDOG);
        `CHK(q[7:0], 8'h00)
        `CHK(q[15:8], 8'h00)
        chk_rd(OFS_STATUS, 32'h1c);
        // An unmapped address reads zero and flags a slave error.
        rd(8'h40);
        `CHK({err, q}, {1'b1, 32'h0})
        wrap_up();
    end

    initial begin
        #(25ns * 20000);
        num_errors++;
        $display("Watchdog expired at t=%0t", $time);
        wrap_up();
    end
endmodule
